// file: common/aze_pkg.sv
// Package: constants and carrier types for the application zone erase authorization block
package aze_pkg;
  // Bit address space
  localparam int unsigned ADDR_W        = 11;
  localparam logic [10:0] ADDR_LAST     = 11'h63F;  // 1599
  // First application zone
  localparam logic [10:0] Z1_FIRST      = 11'h0B0;  // 176
  localparam logic [10:0] Z1_LAST       = 11'h1AF;  // 431
  localparam logic [10:0] Z1_TRIGGER    = 11'h1E0;  // 480
  // Second application zone
  localparam logic [10:0] Z2_FIRST      = 11'h1E0;  // 480
  localparam logic [10:0] Z2_LAST       = 11'h2DF;  // 735
  localparam logic [10:0] Z2_TRIGGER    = 11'h300;  // 768
  // Second zone erase tally bits
  localparam logic [10:0] TALLY_FIRST   = 11'h300;  // 768
  localparam logic [10:0] TALLY_LAST    = 11'h303;  // 771
  // Third application zone
  localparam logic [10:0] Z3_FIRST      = 11'h400;  // 1024
  localparam logic [10:0] Z3_LAST       = 11'h5FF;  // 1535
  localparam logic [10:0] Z3_TRIGGER    = 11'h630;  // 1584
  // Key compare results from the compare logic
  typedef struct packed {
    logic key1_ok;
    logic key2_ok;
    logic key3_ok;
  } aze_cmp_type;
  // Memory command towards the array
  typedef struct packed {
    logic        zone_erase;
    logic [10:0] first;
    logic [10:0] last;
  } aze_erase_type;
  typedef enum logic [1:0] {AZE_OP_WRITE, AZE_OP_ERASE, AZE_OP_COMPARE, AZE_OP_READ} aze_op_type;
endpackage

// file: src/aze_core.sv
// Zone erase authorization and serial data-out control for the application zones
// Summary of operation
// - Level one: erasing any bit of a zone erases the whole zone.
// - Level two: valid first key compare sets first zone erase flag.
// - First flag set: erase at bit 480 erases bits 176-431.
// - After that erase, data line shows the unchanged bit 480.
// - Each falling clock edge but the one ending a programming pulse increments address; outside compare it drives the new bit.
// - Level two: valid second key compare sets second zone erase flag.
// - Second flag set: erase at bit 768 erases bits 480-735.
// - After that erase, data line shows the unchanged bit 768.
// - Tally fuse zero: tally inactive, key compare works alone.
// - Tally on: output zero after tally write; good compare sets flag.
// - Tally on: output zero after tally erase whatever the compare result.
// - Level two: valid third key compare sets third zone erase flag.
// - Third flag set: erase at bit 1584 erases bits 1024-1535.
// - Third flag cleared by reset function or address passing 1599.
// - Compare bit latched on falling edge, compared on the next one.
module aze_core
  import aze_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // Card pins from the reader
  input  wire logic                 i_sclk,
  input  wire logic                 i_card_rst,
  input  wire logic                 i_program_strobe,
  // Data line, open drain
  input  wire logic                 i_io,
  output logic                      o_io,
  output logic                      o_io_oe,
  // Personalization state
  input  wire logic                 i_level_two,
  input  wire logic                 i_tally_enable_fuse,
  // Current operation and key compare status
  input  wire aze_pkg::aze_op_type  i_op,
  input  wire aze_pkg::aze_cmp_type i_cmp,
  input  wire logic                 i_cmp_done,
  // Memory array interface
  input  wire logic                 i_mem_bit,
  output logic [aze_pkg::ADDR_W-1:0] o_addr,
  output aze_pkg::aze_erase_type    o_erase,
  output logic                      o_cmp_bit,
  // Flags
  output logic                      o_first_zone_erase_flag,
  output logic                      o_second_zone_erase_flag,
  output logic                      o_third_zone_erase_flag
);
  import aze_pkg::*;

  // Pin synchronisers, two stages each
  logic [1:0] sclk_sync_reg, rst_sync_reg, pgm_sync_reg, io_sync_reg;
  logic       sclk_d_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_sync_reg <= 2'h0;
      rst_sync_reg  <= 2'h3;
      pgm_sync_reg  <= 2'h0;
      io_sync_reg   <= 2'h3;
      sclk_d_reg    <= 1'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
      rst_sync_reg  <= {rst_sync_reg[0], i_card_rst};
      pgm_sync_reg  <= {pgm_sync_reg[0], i_program_strobe};
      io_sync_reg   <= {io_sync_reg[0], i_io};
      sclk_d_reg    <= sclk_sync_reg[1];
    end
  end

  logic sclk_s, card_rst, pgm_s, sclk_rise, sclk_fall;
  assign sclk_s    = sclk_sync_reg[1];
  assign card_rst  = rst_sync_reg[1];
  assign pgm_s     = pgm_sync_reg[1];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;

  // Programming pulse: strobe high at clock rise starts erase or write
  logic prog_start, erase_start, write_start;
  assign prog_start  = sclk_rise & pgm_s & ~card_rst;
  assign erase_start = prog_start & (i_op == AZE_OP_ERASE);
  assign write_start = prog_start & (i_op == AZE_OP_WRITE);
  // programming fall keeps the address, so the trigger bit is shown next
  logic prog_cycle_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prog_cycle_reg <= 1'h0;
    end else if (prog_start) begin
      prog_cycle_reg <= 1'h1;
    end else if (card_rst || sclk_fall) begin
      prog_cycle_reg <= 1'h0;
    end
  end

  // Address counter
  logic [ADDR_W-1:0] addr_reg;
  logic              addr_inc, addr_wrap;
  assign addr_inc  = sclk_fall & ~card_rst & ~prog_cycle_reg;
  assign addr_wrap = addr_inc & (addr_reg == ADDR_LAST);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_reg <= '0;
    end else if (card_rst) begin
      addr_reg <= '0;
    end else if (addr_inc) begin
      addr_reg <= addr_wrap ? '0 : addr_reg + 11'h001;
    end
  end
  assign o_addr = addr_reg;

  // Compare data: latched on one fall, evaluated on the next
  logic cmp_bit_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmp_bit_reg <= 1'h0;
    end else if (sclk_fall && i_op == AZE_OP_COMPARE) begin
      cmp_bit_reg <= io_sync_reg[1];
    end
  end
  assign o_cmp_bit = cmp_bit_reg;

  // Tally write seen since last reset; with the tally fuse set, flag two is withheld until then
  logic tally_written_reg, in_tally;
  assign in_tally = (addr_reg >= TALLY_FIRST) && (addr_reg <= TALLY_LAST);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tally_written_reg <= 1'h0;
    end else if (card_rst) begin
      tally_written_reg <= 1'h0;
    end else if (write_start && in_tally) begin
      tally_written_reg <= 1'h1;
    end
  end

  // Erase flags; sets take priority over clears
  logic f1_reg, f2_reg, f3_reg, set1, set2, set3, key2_pending_reg;
  assign set1 = i_level_two & i_cmp_done & i_cmp.key1_ok;
  assign set3 = i_level_two & i_cmp_done & i_cmp.key3_ok;
  assign set2 = i_level_two & ((i_cmp_done & i_cmp.key2_ok & ~i_tally_enable_fuse)
              | (key2_pending_reg & tally_written_reg & i_tally_enable_fuse));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      key2_pending_reg <= 1'h0;
    end else if (i_cmp_done && i_cmp.key2_ok) begin
      key2_pending_reg <= 1'h1;
    end else if (card_rst) begin
      key2_pending_reg <= 1'h0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      f1_reg <= 1'h0;
      f2_reg <= 1'h0;
    end else begin
      f1_reg <= set1 | (f1_reg & ~card_rst);
      f2_reg <= set2 | (f2_reg & ~card_rst);
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      f3_reg <= 1'h0;
    end else begin
      f3_reg <= set3 | (f3_reg & ~card_rst & ~addr_wrap);
    end
  end
  assign o_first_zone_erase_flag  = f1_reg;
  assign o_second_zone_erase_flag = f2_reg;
  assign o_third_zone_erase_flag  = f3_reg;

  // Zone erase decode
  aze_erase_type erase_next, erase_reg;
  always_comb begin
    erase_next = '{zone_erase: 1'h0, first: '0, last: '0};
    if (erase_start) begin
      if (!i_level_two) begin
        if (addr_reg >= Z1_FIRST && addr_reg <= Z1_LAST) begin
          erase_next = '{zone_erase: 1'h1, first: Z1_FIRST, last: Z1_LAST};
        end else if (addr_reg >= Z2_FIRST && addr_reg <= Z2_LAST) begin
          erase_next = '{zone_erase: 1'h1, first: Z2_FIRST, last: Z2_LAST};
        end else if (addr_reg >= Z3_FIRST && addr_reg <= Z3_LAST) begin
          erase_next = '{zone_erase: 1'h1, first: Z3_FIRST, last: Z3_LAST};
        end
      end else if (addr_reg == Z1_TRIGGER && f1_reg) begin
        erase_next = '{zone_erase: 1'h1, first: Z1_FIRST, last: Z1_LAST};
      end else if (addr_reg == Z2_TRIGGER && f2_reg) begin
        erase_next = '{zone_erase: 1'h1, first: Z2_FIRST, last: Z2_LAST};
      end else if (addr_reg == Z3_TRIGGER && f3_reg) begin
        erase_next = '{zone_erase: 1'h1, first: Z3_FIRST, last: Z3_LAST};
      end
    end
  end
  // One-cycle erase command to the array
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      erase_reg <= '{zone_erase: 1'h0, first: '0, last: '0};
    end else begin
      erase_reg <= erase_next;
    end
  end
  assign o_erase = erase_reg;

  // Forced-zero output after tally write or erase hides the compare result
  logic force_zero_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      force_zero_reg <= 1'h0;
    end else if (card_rst || addr_inc) begin
      force_zero_reg <= 1'h0;
    end else if (prog_start && in_tally && i_tally_enable_fuse && i_level_two) begin
      force_zero_reg <= 1'h1;
    end
  end

  // Data line drive: open drain, pull low only for a zero
  logic out_bit_reg, drive_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_bit_reg <= 1'h1;
      drive_reg   <= 1'h0;
    end else begin
      // trigger bit kept, array value shown
      out_bit_reg <= force_zero_reg ? 1'h0 : i_mem_bit;
      drive_reg   <= ~pgm_s & (i_op != AZE_OP_COMPARE);
    end
  end
  assign o_io    = 1'h0;
  assign o_io_oe = drive_reg & ~out_bit_reg;

  // Assertions
  property p_flag3_clear;
    @(posedge i_clk) disable iff (!i_rstn)
    (addr_wrap && !set3) |=> !f3_reg;
  endproperty
  a_flag3_clear: assert property (p_flag3_clear) else $error("third flag survived wrap");
  property p_flag1_reset;
    @(posedge i_clk) disable iff (!i_rstn)
    (card_rst && !set1) |=> !f1_reg;
  endproperty
  a_flag1_reset: assert property (p_flag1_reset) else $error("first flag survived reset");
  property p_set1;
    @(posedge i_clk) disable iff (!i_rstn) (i_level_two && i_cmp_done && i_cmp.key1_ok) |=> f1_reg;
  endproperty
  a_set1: assert property (p_set1) else $error("first flag not set");
  property p_set3;
    @(posedge i_clk) disable iff (!i_rstn) (i_level_two && i_cmp_done && i_cmp.key3_ok) |=> f3_reg;
  endproperty
  a_set3: assert property (p_set3) else $error("third flag not set");
  property p_z1;
    @(posedge i_clk) disable iff (!i_rstn)
    (erase_start && i_level_two && addr_reg == Z1_TRIGGER && f1_reg)
      |=> (o_erase.zone_erase && o_erase.first == Z1_FIRST && o_erase.last == Z1_LAST);
  endproperty
  a_z1: assert property (p_z1) else $error("first zone erase missing");
  property p_z2;
    @(posedge i_clk) disable iff (!i_rstn)
    (erase_start && i_level_two && addr_reg == Z2_TRIGGER && f2_reg)
      |=> (o_erase.zone_erase && o_erase.first == Z2_FIRST && o_erase.last == Z2_LAST);
  endproperty
  a_z2: assert property (p_z2) else $error("second zone erase missing");
  property p_z3;
    @(posedge i_clk) disable iff (!i_rstn)
    (erase_start && i_level_two && addr_reg == Z3_TRIGGER && f3_reg)
      |=> (o_erase.zone_erase && o_erase.first == Z3_FIRST && o_erase.last == Z3_LAST);
  endproperty
  a_z3: assert property (p_z3) else $error("third zone erase missing");
  property p_noflag;
    @(posedge i_clk) disable iff (!i_rstn)
    (erase_start && i_level_two && !f1_reg && !f2_reg && !f3_reg) |=> !o_erase.zone_erase;
  endproperty
  a_noflag: assert property (p_noflag) else $error("zone erase without flag");
  property p_inc;
    @(posedge i_clk) disable iff (!i_rstn)
    (addr_inc && !addr_wrap) |=> (addr_reg == $past(addr_reg) + 11'h001);
  endproperty
  a_inc: assert property (p_inc) else $error("address not incremented");
  property p_hide;
    @(posedge i_clk) disable iff (!i_rstn) force_zero_reg |=> !out_bit_reg;
  endproperty
  a_hide: assert property (p_hide) else $error("tally result leaked");
  property p_notally;
    @(posedge i_clk) disable iff (!i_rstn)
    (!i_tally_enable_fuse && i_level_two && i_cmp_done && i_cmp.key2_ok) |=> f2_reg;
  endproperty
  a_notally: assert property (p_notally) else $error("second flag not set");
  c_z1: cover property (@(posedge i_clk) disable iff (!i_rstn) erase_start && f1_reg);
  c_tally: cover property (@(posedge i_clk) disable iff (!i_rstn) force_zero_reg && set2);
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_rstn) addr_wrap && f3_reg);
endmodule // aze_core

// file: testbench/aze_core_bench.sv
// Self-checking bench for the zone erase core
module aze_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import aze_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, lvl2 = 1'b0, fuse = 1'b0, cmp_done = 1'b0;
  logic sclk, crst, prog, io_low, io, oe, io_out, cmp_bit, f1, f2, f3;
  aze_op_type op;
  aze_cmp_type cmp = '0;
  aze_erase_type ers, seen = '0;
  logic seen_clr = 1'b0;
  logic [ADDR_W-1:0] addr, cur;
  int miscompares = 0, n_checks = 0;
  always #50 clk = ~clk;
  // Open drain line with pull-up
  assign io = ~(oe | io_low);
  aze_core dut_u (.i_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_card_rst(crst), .i_program_strobe(prog),
    .i_io(io), .o_io(io_out), .o_io_oe(oe), .i_level_two(lvl2), .i_tally_enable_fuse(fuse), .i_op(op),
    .i_cmp(cmp), .i_cmp_done(cmp_done), .i_mem_bit(^addr), .o_addr(addr), .o_erase(ers), .o_cmp_bit(cmp_bit),
    .o_first_zone_erase_flag(f1), .o_second_zone_erase_flag(f2), .o_third_zone_erase_flag(f3));
  aze_reader_model reader_u (.i_clk(clk), .o_sclk(sclk), .o_card_rst(crst), .o_program_strobe(prog),
    .o_io_low(io_low), .o_op(op));
  // Erase pulse lasts one cycle, so hold it
  always @(posedge clk) begin
    if (ers.zone_erase) begin
      seen <= ers;
    end else if (seen_clr) begin
      seen <= '0;
    end
  end
  task automatic check_val(input logic [22:0] got, input logic [22:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_erase(input aze_erase_type exp);
    check_val(seen, exp);
  endtask
  task automatic goto(input logic [10:0] a);
    reader_u.pulse(int'(a) - int'(cur));
    cur = a;
    check_val(addr, a);
  endtask
  task automatic reset_card();
    reader_u.card_reset();
    cur = '0;
    check_val(addr, 23'h0);
    check_val({f1, f2, f3}, 23'h0);
  endtask
  task automatic cmp_pulse(input aze_cmp_type m);
    cmp = m;
    cmp_done = 1'b1;
    @(negedge clk);
    cmp_done = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic erase_at(input logic [10:0] a, input logic [10:0] f, input logic [10:0] l);
    goto(a);
    seen_clr = 1'b1;
    @(negedge clk);
    seen_clr = 1'b0;
    reader_u.prog(AZE_OP_ERASE);
    check_erase({1'b1, f, l});
    check_val(addr, a);
    check_val(io_out, 1'b0);
    check_val(oe, ~^a);
    reader_u.pulse(1);
    cur = a + 11'h001;
    check_val(addr, cur);
    check_val(oe, ~^cur);
  endtask
  task automatic test_level_one();
    lvl2 = 1'b0;
    reset_card();
    erase_at(11'h0C8, Z1_FIRST, Z1_LAST);
    erase_at(11'h44C, Z3_FIRST, Z3_LAST);
    $display("Test level_one done");
  endtask
  task automatic test_zone(input logic [2:0] m, input logic [10:0] t, input logic [10:0] f, input logic [10:0] l);
    lvl2 = 1'b1;
    fuse = 1'b0;
    reset_card();
    cmp_pulse(3'h0);
    check_val({f1, f2, f3}, 23'h0);
    cmp_pulse(m);
    check_val({f1, f2, f3}, m);
    erase_at(t, f, l);
    $display("Test zone %h done", m);
  endtask
  task automatic test_wrap();
    goto(ADDR_LAST);
    check_val(f3, 1'b1);
    reader_u.pulse(1);
    cur = '0;
    check_val(addr, 23'h0);
    check_val(f3, 1'b0);
    $display("Test wrap done");
  endtask
  task automatic test_tally(input logic ok);
    lvl2 = 1'b1;
    fuse = 1'b1;
    reset_card();
    cmp_pulse({1'b0, ok, 1'b0});
    // bit 768 already used, 769 reads one
    goto(TALLY_FIRST + 11'h001);
    reader_u.prog(AZE_OP_WRITE);
    check_val(oe, 1'b1);
    check_val(f2, ok);
    reader_u.prog(AZE_OP_ERASE);
    check_val(oe, 1'b1);
    reader_u.pulse(1);
    cur = cur + 11'h001;
    check_val(oe, ~^cur);
    $display("Test tally %0d done", ok);
  endtask
  task automatic test_compare();
    reset_card();
    for (int b = 0; b < 2; b++) begin
      reader_u.cmp_in(b[0]);
      cur = cur + 11'h001;
      check_val(cmp_bit, b[0]);
      check_val(addr, cur);
    end
    $display("Test compare done");
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    cur = '0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    test_compare();
    test_level_one();
    test_zone(3'b100, Z1_TRIGGER, Z1_FIRST, Z1_LAST);
    test_zone(3'b010, Z2_TRIGGER, Z2_FIRST, Z2_LAST);
    test_zone(3'b001, Z3_TRIGGER, Z3_FIRST, Z3_LAST);
    test_wrap();
    test_tally(1'b1);
    test_tally(1'b0);
    conclude();
  end
endmodule // aze_core_bench

// file: testbench/aze_reader_model.sv
// Card reader model driving the serial pins of the zone erase core
module aze_reader_model (
  // Clock
  input  wire logic           i_clk,
  // Reader pins
  output logic                o_sclk,
  output logic                o_card_rst,
  output logic                o_program_strobe,
  output logic                o_io_low,
  output aze_pkg::aze_op_type o_op
);
  timeunit 1ns;
  timeprecision 1ns;
  import aze_pkg::*;
  initial begin
    o_sclk = 1'b0;
    o_card_rst = 1'b0;
    o_program_strobe = 1'b0;
    o_io_low = 1'b0;
    o_op = AZE_OP_READ;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      o_sclk = 1'b1;
      wait_n(5);
      o_sclk = 1'b0;
      wait_n(5);
    end
  endtask
  // Strobe falls before the clock, else data-out is lost
  task automatic prog(input aze_op_type op);
    o_op = op;
    o_program_strobe = 1'b1;
    wait_n(5);
    o_sclk = 1'b1;
    wait_n(8);
    o_program_strobe = 1'b0;
    o_op = AZE_OP_READ;
    wait_n(5);
    o_sclk = 1'b0;
    wait_n(6);
  endtask
  // Input held well past the fall
  task automatic cmp_in(input logic b);
    o_op = AZE_OP_COMPARE;
    o_io_low = ~b;
    pulse(1);
    o_io_low = 1'b0;
    o_op = AZE_OP_READ;
  endtask
  task automatic card_reset();
    o_card_rst = 1'b1;
    wait_n(6);
    o_card_rst = 1'b0;
    wait_n(6);
  endtask
endmodule // aze_reader_model
